// [hsrp_pkg.sv]
package hsrp_pkg;
  // A2,A1 encodings of the writable registers
  localparam logic [1:0] HSRP_SEL_CMD  = 2'h0;
  localparam logic [1:0] HSRP_SEL_VEC  = 2'h1;
  localparam logic [1:0] HSRP_SEL_DATA = 2'h2;
  localparam logic [7:0] HSRP_LOCK_SET = 8'hff;
  localparam logic [7:0] HSRP_LOCK_CLR = 8'hfe;
  localparam logic [7:0] HSRP_UPPER_FILL = 8'hff;
  localparam logic [7:0] HSRP_VEC_RST  = 8'h0f;
  localparam logic [15:0] HSRP_WORD_RST = 16'h0000;
  localparam int HSRP_SYNC_STAGES = 2;
  typedef enum logic [2:0] {
    HSRP_IDLE, HSRP_ACK, HSRP_HIGH, HSRP_WAIT_OFF
  } hsrp_state_t;
endpackage

// [hsrp_host_port.sv]
`timescale 1ns/100ps
module hsrp_host_port
  import hsrp_pkg::*;
(
  input  wire logic        i_mclk,                 // parallel clock
  input  wire logic        i_sys_rst,              // async reset, high
  input  wire logic        i_chip_sel_n,           // chip select
  input  wire logic        i_vector_fetch_ack_n,   // vector fetch ack
  input  wire logic        i_rd_wr,                // 1 read, 0 write
  input  wire logic [2:1]  i_addr,                 // A2..A1
  input  wire logic        i_upper_strobe_or_addr0_n, // upper strobe/A0
  input  wire logic        i_lower_strobe_or_byte_strobe_n, // lower/ds
  input  wire logic        i_bus_8bit,             // 8-bit bus mode
  input  wire logic [15:0] i_data,                 // data bus in
  output logic      [15:0] o_data,                 // data bus out
  output logic             o_data_oe_n,            // low: drive data
  output logic             o_transfer_ack_n,       // ack level
  output logic             o_transfer_ack_oe_n,    // low: drive ack
  input  wire logic        i_bus_master,           // device owns bus
  input  wire logic        i_lock_set,             // lock flag state
  output logic      [15:0] o_command_reg,          // command register
  output logic             o_command_stb,          // new command pulse
  output logic      [7:0]  o_interrupt_vector_reg, // vector register
  output logic      [15:0] o_host_data_reg,        // data register
  output logic             o_addr_error            // address error pulse
);
  // chip select, vector fetch and both strobes cross an unrelated clock, so synchronise
  logic [HSRP_SYNC_STAGES-1:0] cs_sync;
  logic [HSRP_SYNC_STAGES-1:0] vector_fetch_ack_n_sync;
  logic [HSRP_SYNC_STAGES-1:0] us_sync;
  logic [HSRP_SYNC_STAGES-1:0] ls_sync;

  // chip select
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cs_sync <= '1;
    end else begin
      cs_sync <= {cs_sync[HSRP_SYNC_STAGES-2:0], i_chip_sel_n};
    end
  end

  // vector fetch acknowledge
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      vector_fetch_ack_n_sync <= '1;
    end else begin
      vector_fetch_ack_n_sync <= {vector_fetch_ack_n_sync[HSRP_SYNC_STAGES-2:0],
                    i_vector_fetch_ack_n};
    end
  end

  // upper strobe, or A0 on an 8-bit bus
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      us_sync <= '1;
    end else begin
      us_sync <= {us_sync[HSRP_SYNC_STAGES-2:0],
                  i_upper_strobe_or_addr0_n};
    end
  end

  // lower strobe, the only strobe on an 8-bit bus
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ls_sync <= '1;
    end else begin
      ls_sync <= {ls_sync[HSRP_SYNC_STAGES-2:0],
                  i_lower_strobe_or_byte_strobe_n};
    end
  end

  // only the last stage is read; earlier ones may be metastable
  logic cs;
  logic vector_fetch_ack_n;
  logic us;
  logic ls;
  logic vector_fetch_ack_n_prev;
  logic any_strobe;
  logic hi_lane;
  logic lo_lane;

  assign cs   = ~cs_sync[HSRP_SYNC_STAGES-1];
  assign vector_fetch_ack_n = ~vector_fetch_ack_n_sync[HSRP_SYNC_STAGES-1];
  assign us   = ~us_sync[HSRP_SYNC_STAGES-1];
  assign ls   = ~ls_sync[HSRP_SYNC_STAGES-1];

  // 8-bit bus: upper pin is A0, lower pin the only strobe
  function automatic logic strobe_seen(input logic bus8,
                                       input logic up,
                                       input logic lo);
    if (bus8) begin
      strobe_seen = lo;
    end else begin
      strobe_seen = up | lo;
    end
  endfunction

  function automatic logic valid_target(input logic [1:0] a);
    valid_target = (a == HSRP_SEL_CMD) || (a == HSRP_SEL_VEC) ||
                   (a == HSRP_SEL_DATA);
  endfunction

  function automatic logic [15:0] merge_lanes(input logic [15:0] cur,
                                              input logic [15:0] din,
                                              input logic        hi,
                                              input logic        lo);
    merge_lanes = cur;
    if (hi) begin
      merge_lanes[15:8] = din[15:8];
    end
    if (lo) begin
      merge_lanes[7:0] = din[7:0];
    end
  endfunction

  // upper lane of every read is all ones
  function automatic logic [15:0] read_word(input logic [7:0] low);
    read_word = {HSRP_UPPER_FILL, low};
  endfunction

  function automatic logic [7:0] lock_code(input logic set);
    if (set) begin
      lock_code = HSRP_LOCK_SET;
    end else begin
      lock_code = HSRP_LOCK_CLR;
    end
  endfunction

  assign any_strobe = strobe_seen(i_bus_8bit, us, ls);

  always_comb begin
    if (i_bus_8bit) begin
      // 8-bit data always travels on the low lane
      hi_lane = 1'b0;
      lo_lane = ls;
    end else begin
      hi_lane = us;
      lo_lane = ls;
    end
  end

  hsrp_state_t state;
  hsrp_state_t next_state;
  logic        vector_fetch_ack_n_cyc;
  logic        release_cond;
  logic        start_rd;
  logic        start_wr;
  logic        start_vector_fetch_ack_n;
  logic        start_any;
  logic        take_wr;
  logic        next_data_oe_n;
  logic        next_command_stb;
  logic        next_addr_error;

  // a vector fetch ends on its select or lower strobe dropping, any other access on its strobes or chip select dropping
  always_comb begin
    if (vector_fetch_ack_n_cyc) begin
      release_cond = ~vector_fetch_ack_n | ~ls;
    end else begin
      release_cond = ~any_strobe | ~cs;
    end
  end

  always_comb begin
    start_rd   = 1'b0;
    start_wr   = 1'b0;
    start_vector_fetch_ack_n = 1'b0;
    if (cs && !vector_fetch_ack_n && any_strobe) begin
      start_rd = i_rd_wr;
      start_wr = ~i_rd_wr & valid_target(i_addr);
    end else if (vector_fetch_ack_n && !cs && ls) begin
      start_vector_fetch_ack_n = ~i_bus_master;
    end
  end

  assign start_any = start_rd | start_wr | start_vector_fetch_ack_n;
  assign take_wr   = (state == HSRP_IDLE) & start_wr;

  always_comb begin
    next_state = state;
    unique case (state)
      HSRP_IDLE: begin
        if (start_any) begin
          next_state = HSRP_ACK;
        end
      end
      HSRP_ACK: begin
        if (release_cond) begin
          next_state = HSRP_HIGH;
        end
      end
      HSRP_HIGH: begin
        next_state = HSRP_WAIT_OFF;
      end
      HSRP_WAIT_OFF: begin
        // avoid re-triggering on the same still-held strobes
        if (release_cond || !(cs | vector_fetch_ack_n)) begin
          next_state = HSRP_IDLE;
        end
      end
      default: begin
        next_state = HSRP_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state <= HSRP_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // kind of cycle taken, held until the next take
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      vector_fetch_ack_n_cyc <= 1'b0;
    end else if (state == HSRP_IDLE && start_any) begin
      vector_fetch_ack_n_cyc <= start_vector_fetch_ack_n;
    end
  end

  // read data: lock flag or vector on low lane, ones on upper lane
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_data <= HSRP_WORD_RST;
    end else if (state == HSRP_IDLE) begin
      if (start_vector_fetch_ack_n) begin
        o_data <= read_word(o_interrupt_vector_reg);
      end else if (start_rd) begin
        o_data <= read_word(lock_code(i_lock_set));
      end
    end
  end

  always_comb begin
    next_data_oe_n = o_data_oe_n;
    if (state == HSRP_IDLE) begin
      next_data_oe_n = ~(start_rd | start_vector_fetch_ack_n);
    end else if (state == HSRP_ACK && release_cond) begin
      next_data_oe_n = 1'b1;
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_data_oe_n <= 1'b1;
    end else begin
      o_data_oe_n <= next_data_oe_n;
    end
  end

  // ack: low in ACK, driven high one cycle, then floated
  always_comb begin
    o_transfer_ack_n    = 1'b1;
    o_transfer_ack_oe_n = 1'b1;
    unique case (state)
      HSRP_ACK: begin
        o_transfer_ack_n    = 1'b0;
        o_transfer_ack_oe_n = 1'b0;
      end
      HSRP_HIGH: begin
        // pull the pin up fast before letting go of it
        o_transfer_ack_n    = 1'b1;
        o_transfer_ack_oe_n = 1'b0;
      end
      HSRP_IDLE, HSRP_WAIT_OFF: begin
        o_transfer_ack_n    = 1'b1;
        o_transfer_ack_oe_n = 1'b1;
      end
      default: begin
        o_transfer_ack_n    = 1'b1;
        o_transfer_ack_oe_n = 1'b1;
      end
    endcase
  end

  // write capture with byte lanes, same cycle as ack falls
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_command_reg <= HSRP_WORD_RST;
    end else if (take_wr && i_addr == HSRP_SEL_CMD) begin
      o_command_reg <= merge_lanes(o_command_reg, i_data,
                                   hi_lane, lo_lane);
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_interrupt_vector_reg <= HSRP_VEC_RST;
    end else if (take_wr && i_addr == HSRP_SEL_VEC && lo_lane) begin
      o_interrupt_vector_reg <= i_data[7:0];
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_host_data_reg <= HSRP_WORD_RST;
    end else if (take_wr && i_addr == HSRP_SEL_DATA) begin
      o_host_data_reg <= merge_lanes(o_host_data_reg, i_data,
                                     hi_lane, lo_lane);
    end
  end

  always_comb begin
    next_command_stb = 1'b0;
    if (take_wr && i_addr == HSRP_SEL_CMD) begin
      // one pulse per accepted command, not per held cycle
      next_command_stb = 1'b1;
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_command_stb <= 1'b0;
    end else begin
      o_command_stb <= next_command_stb;
    end
  end

  // edge of the synchronised level, so a held fetch flags once
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      vector_fetch_ack_n_prev <= 1'b0;
    end else begin
      vector_fetch_ack_n_prev <= vector_fetch_ack_n;
    end
  end

  always_comb begin
    next_addr_error = 1'b0;
    if (vector_fetch_ack_n && !vector_fetch_ack_n_prev && i_bus_master) begin
      next_addr_error = 1'b1;
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_addr_error <= 1'b0;
    end else begin
      o_addr_error <= next_addr_error;
    end
  end
endmodule

// [hsrp_port_props.sv]
`timescale 1ns/100ps
module hsrp_port_props (
  input wire logic        i_mclk,               // clock
  input wire logic        i_sys_rst,            // reset
  input wire logic        i_chip_sel_n,         // select
  input wire logic        i_vector_fetch_ack_n, // vector fetch
  input wire logic        i_rd_wr,              // direction
  input wire logic [2:1]  i_addr,               // a2..a1
  input wire logic        i_lower_strobe_or_byte_strobe_n, // lower strobe
  input wire logic [15:0] o_data,               // read data
  input wire logic        o_data_oe_n,          // data enable
  input wire logic        o_transfer_ack_n,     // ack
  input wire logic        o_transfer_ack_oe_n,  // ack enable
  input wire logic        o_command_stb         // command pulse
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  sequence host_read;
    !i_chip_sel_n && i_rd_wr && !i_lower_strobe_or_byte_strobe_n;
  endsequence
  // four idle cycles cover the two synchroniser stages and the release
  sequence deselected;
    (i_chip_sel_n && i_vector_fetch_ack_n) [*4];
  endsequence
  a_read_acked: assert property (
    host_read |-> ##[0:5] !o_transfer_ack_n) else $error("read not acked");
  a_lock_code: assert property (
    !o_data_oe_n && !i_chip_sel_n |-> o_data[7:1] == 7'h7f)
    else $error("lock flag code wrong");
  a_ack_driven: assert property (
    !o_transfer_ack_n |-> !o_transfer_ack_oe_n) else $error("ack not driven");
  a_high_first: assert property (
    $rose(o_transfer_ack_oe_n) |-> $past(o_transfer_ack_n))
    else $error("ack floated while low");
  a_release_ack: assert property (
    deselected |=> o_transfer_ack_n) else $error("ack held after release");
  a_data_float: assert property (
    deselected |=> o_data_oe_n) else $error("data held after release");
  a_no_bad_write: assert property (
    (!i_chip_sel_n && !i_rd_wr && i_addr == 2'h3) [*4] |-> o_transfer_ack_n)
    else $error("write to unwritable place acked");
  a_stb_single: assert property (
    o_command_stb |=> !o_command_stb) else $error("command pulse too long");
endmodule
bind hsrp_host_port hsrp_port_props props_u (.i_mclk, .i_sys_rst,
  .i_chip_sel_n, .i_vector_fetch_ack_n, .i_rd_wr, .i_addr,
  .i_lower_strobe_or_byte_strobe_n, .o_data, .o_data_oe_n,
  .o_transfer_ack_n, .o_transfer_ack_oe_n, .o_command_stb);

// [hsrp_host_model.sv]
`timescale 1ns/100ps
module hsrp_host_model (
  input  wire logic        i_mclk,    // clock
  input  wire logic [15:0] i_rd_data, // device data
  input  wire logic        i_ack_n,   // ack level
  input  wire logic        i_ack_oe_n,// ack enable
  output logic             o_cs_n,    // chip select
  output logic             o_vector_fetch_ack_n_n,  // vector fetch
  output logic             o_rd_wr,   // direction
  output logic [2:1]       o_addr,    // a2..a1
  output logic             o_uds_n,   // upper strobe
  output logic             o_lds_n,   // lower strobe
  output logic [15:0]      o_wr_data  // write data
);
  wire ack_w = i_ack_oe_n | i_ack_n; // pull-up when floated
  initial {o_cs_n, o_vector_fetch_ack_n_n, o_rd_wr, o_addr, o_uds_n, o_lds_n} = 7'h7f;
  initial o_wr_data = 16'h0000;
  task automatic xfer(input logic vector_fetch_ack_n, rw, input logic [2:1] a,
    input logic u, l, input logic [15:0] wd,
    output logic [15:0] rd, output logic ok);
    ok = 1'b0;
    rd = 16'h0000;
    @(posedge i_mclk);
    {o_cs_n, o_vector_fetch_ack_n_n} <= vector_fetch_ack_n ? 2'b10 : 2'b01;
    {o_rd_wr, o_addr, o_uds_n, o_lds_n} <= {rw, a, ~u, ~l};
    o_wr_data <= rw ? ~o_wr_data : wd;
    for (int i = 0; i < 8 && !ok; i++) begin
      @(posedge i_mclk);
      ok = !ack_w;
      rd = i_rd_data;
    end
    {o_cs_n, o_vector_fetch_ack_n_n, o_uds_n, o_lds_n} <= 4'hf;
    o_wr_data <= ~o_wr_data; // released bus shows no stale value
    repeat (6) @(posedge i_mclk);
  endtask
endmodule

// [testbench.sv]
`timescale 1ns/100ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin \
  n_mismatch++; $display("mismatch at %0t: %h vs %h", $time, a, b); end end
module testbench;
  import hsrp_pkg::*;
  logic        i_mclk, i_sys_rst, i_bus_8bit, i_bus_master, i_lock_set;
  logic        cs_n, vector_fetch_ack_n_n, rd_wr, uds_n, lds_n, ack_n, ack_oe_n, ok;
  logic        data_oe_n, cmd_stb, addr_err;
  logic [2:1]  addr;
  logic [7:0]  vec;
  logic [15:0] wdata, rdata, rd, cmd, dreg;
  int          n_mismatch = 0, checks_done = 0, n_err = 0;
  hsrp_host_port dut_u (.i_mclk, .i_sys_rst, .i_chip_sel_n(cs_n),
    .i_vector_fetch_ack_n(vector_fetch_ack_n_n), .i_rd_wr(rd_wr), .i_addr(addr),
    .i_upper_strobe_or_addr0_n(uds_n), .i_bus_8bit, .i_data(wdata),
    .i_lower_strobe_or_byte_strobe_n(lds_n), .o_data(rdata),
    .o_data_oe_n(data_oe_n), .o_transfer_ack_n(ack_n), .i_lock_set,
    .o_transfer_ack_oe_n(ack_oe_n), .i_bus_master, .o_command_reg(cmd),
    .o_command_stb(cmd_stb), .o_interrupt_vector_reg(vec),
    .o_host_data_reg(dreg), .o_addr_error(addr_err));
  hsrp_host_model host_u (.i_mclk, .i_rd_data(rdata), .i_ack_n(ack_n),
    .i_ack_oe_n(ack_oe_n), .o_cs_n(cs_n), .o_vector_fetch_ack_n_n(vector_fetch_ack_n_n),
    .o_rd_wr(rd_wr), .o_addr(addr), .o_uds_n(uds_n), .o_lds_n(lds_n),
    .o_wr_data(wdata));
  always @(posedge i_mclk) n_err += (addr_err === 1'b1);
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    i_mclk = 1'b0;
    forever #32 i_mclk = ~i_mclk;
  end
  initial begin
    repeat (3000) @(posedge i_mclk);
    n_mismatch++;
    report_and_stop();
  end
  initial begin
    {i_sys_rst, i_bus_8bit, i_bus_master, i_lock_set} = 4'h8;
    repeat (10) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    for (int k = 0; k < 8; k++) begin
      @(posedge i_mclk);
      i_lock_set <= k[2];
      host_u.xfer(0, 1, k[1:0], 1, 1, 0, rd, ok);
      `CHK({ok, rd}, {9'h1ff, 7'h7f, k[2]})
    end
    host_u.xfer(0, 0, HSRP_SEL_CMD, 1, 1, 16'h1234, rd, ok);
    `CHK({ok, cmd}, 17'h11234)
    host_u.xfer(0, 0, HSRP_SEL_DATA, 1, 0, 16'habcd, rd, ok);
    `CHK(dreg, 16'hab00)
    host_u.xfer(0, 0, 2'h3, 1, 1, 16'h5555, rd, ok);
    `CHK(ok, 1'b0)
    i_bus_8bit <= 1'b1;
    host_u.xfer(0, 0, HSRP_SEL_VEC, 1, 1, 16'h993c, rd, ok);
    `CHK(vec, 8'h3c)
    host_u.xfer(1, 1, 2'h0, 0, 1, 0, rd, ok);
    `CHK({ok, rd[7:0]}, 9'h13c)
    i_bus_master <= 1'b1;
    host_u.xfer(1, 1, 2'h0, 0, 1, 0, rd, ok);
    `CHK({ok, n_err}, {1'b0, 32'sd1})
    report_and_stop();
  end
endmodule
